// ---- hdl/gcr_cfg_if.sv ----
`timescale 1ns/1ps
interface gcr_cfg_if;
    gcr_pkg::gcr_conf_s conf;
    modport regs (output conf);
    modport route (input conf);
endinterface : gcr_cfg_if

// ---- hdl/gcr_pkg.sv ----
package gcr_pkg;

    typedef logic [31:0] gcr_word_t;
    typedef logic [7:0] gcr_access_t;
    typedef logic [6:0] gcr_index_t;

    // Field order matches bit positions, msb first
    typedef struct packed {
        logic lock;
        logic axis_b_direction_invert;
        logic axis_a_direction_invert;
        logic test_mode;
        logic b_left_alt;
        logic b_enc_enable;
        logic a_left_alt;
        logic poscmp_map;
        logic axis_b_external_pulse_control;
        logic axis_a_external_pulse_control;
        logic single_motor;
    } gcr_conf_s;

endpackage : gcr_pkg

// ---- hdl/gcr_regs.svh ----
`ifndef GCR_REGS_SVH
`define GCR_REGS_SVH

// Access byte: top bit marks a write
`define GCR_WRITE_FLAG 8'h80
`define GCR_WRITE_BIT 7

// Register indices
`define GCR_ADDR_CONF 7'h00
`define GCR_ADDR_STATUS 7'h01

// Widths and reset values
`define GCR_CONF_WIDTH 11
`define GCR_STATUS_WIDTH 3
`define GCR_CONF_RESET 11'h000
`define GCR_STATUS_RESET 3'h1
`define GCR_TEST_SEL_WIDTH 4

// Configuration field positions
`define GCR_BIT_SINGLE 0
`define GCR_BIT_A_EXT 1
`define GCR_BIT_B_EXT 2
`define GCR_BIT_POSCMP_MAP 3
`define GCR_BIT_A_LEFT_ALT 4
`define GCR_BIT_B_ENC_ENABLE 5
`define GCR_BIT_B_LEFT_ALT 6
`define GCR_BIT_TEST_MODE 7
`define GCR_BIT_A_INVERT 8
`define GCR_BIT_B_INVERT 9
`define GCR_BIT_LOCK 10

// Status field positions
`define GCR_ST_RESET 0
`define GCR_ST_DRV_A 1
`define GCR_ST_DRV_B 2

`endif

// ---- hdl/gcr_route.sv ----
`timescale 1ns/1ps
`include "gcr_regs.svh"
module gcr_route (
    input wire logic i_clk,
    input wire logic i_reset,
    gcr_cfg_if.route cfg,
    input wire logic [1:0] i_ramp_step,
    input wire logic [1:0] i_ramp_dir,
    input wire logic [1:0] i_pin_step,
    input wire logic [1:0] i_pin_dir,
    input wire logic i_interface_select,
    input wire logic [1:0] i_left_limit_pin,
    input wire logic [1:0] i_spi_limit_pin,
    input wire logic [1:0] i_general_pin,
    input wire logic i_position_compare_pulse,
    input wire logic i_position_irq,
    input wire logic [1:0] i_enc_a_pins,
    output logic [1:0] o_drv_step,
    output logic [1:0] o_drv_dir,
    output logic [1:0] o_ramp_unused,
    output logic [1:0] o_left_limit,
    output logic [1:0] o_enc_a_pins_out,
    output logic [1:0] o_enc_a_pins_oe,
    output logic [1:0] o_enc_a_in
);
    import gcr_pkg::*;

    logic [1:0] ext;
    logic [1:0] inv;
    logic [1:0] alt;
    logic [1:0] drv_step_q;
    logic [1:0] drv_dir_q;
    logic [1:0] left_limit_q;
    logic [1:0] enc_a_in_q;

    assign ext = {cfg.conf.axis_b_external_pulse_control, cfg.conf.axis_a_external_pulse_control};
    assign inv = {cfg.conf.axis_b_direction_invert, cfg.conf.axis_a_direction_invert};
    assign alt = {cfg.conf.b_left_alt, cfg.conf.a_left_alt};

    ////////////////////////////////////////////////////////////////////////////
    // Per axis step, direction and limit routing
    for (genvar g = 0; g < 2; g++) begin : g_axis
        logic src;
        logic step_d;
        logic dir_d;
        // Stage b copies axis a in parallel mode
        assign src = (g == 1 && cfg.conf.single_motor) ? 1'b0 : 1'b1; // RQ3
        assign step_d = ext[src ? g : 0] ? i_pin_step[src ? g : 0] : i_ramp_step[src ? g : 0]; // RQ4 RQ5
        assign dir_d = (ext[src ? g : 0] ? i_pin_dir[src ? g : 0] : i_ramp_dir[src ? g : 0])
                       ^ inv[src ? g : 0]; // RQ10 RQ11

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                drv_step_q[g] <= 1'b0;
                drv_dir_q[g] <= 1'b0;
            end else begin
                drv_step_q[g] <= step_d;
                drv_dir_q[g] <= dir_d;
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                left_limit_q[g] <= 1'b0;
            end else if (alt[g]) begin
                left_limit_q[g] <= i_interface_select ? i_general_pin[g] : i_spi_limit_pin[g]; // RQ7 RQ8
            end else begin
                left_limit_q[g] <= i_left_limit_pin[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Encoder a pins carry compare pulse and interrupt when mapped
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            enc_a_in_q <= 2'h0;
        end else begin
            enc_a_in_q <= cfg.conf.poscmp_map ? 2'h0 : i_enc_a_pins; // RQ6
        end
    end

    assign o_enc_a_pins_out = {i_position_irq, i_position_compare_pulse}; // RQ6
    assign o_enc_a_pins_oe = {2{cfg.conf.poscmp_map}}; // RQ6
    assign o_ramp_unused = ext;
    assign o_drv_step = drv_step_q;
    assign o_drv_dir = drv_dir_q;
    assign o_left_limit = left_limit_q;
    assign o_enc_a_in = enc_a_in_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ext_route_a: assert property (ext[0] |=> o_drv_step[0] == $past(i_pin_step[0])) // RQ4
        else $error("axis a step not taken from pin");
    ramp_route_a: assert property (!ext[1] && !cfg.conf.single_motor |=>
        o_drv_step[1] == $past(i_ramp_step[1])) // RQ5
        else $error("axis b step not taken from ramp");
    single_follow_a: assert property ($past(cfg.conf.single_motor) |-> o_drv_step[1] == o_drv_step[0]
        && o_drv_dir[1] == o_drv_dir[0]) // RQ3
        else $error("stage b not following axis a");
    dir_invert_a: assert property (inv[0] && !ext[0] |=> o_drv_dir[0] == !$past(i_ramp_dir[0])) // RQ10
        else $error("axis a direction not inverted");
    dir_invert_b: assert property (inv[1] && ext[1] && !cfg.conf.single_motor |=>
        o_drv_dir[1] == !$past(i_pin_dir[1])) // RQ11
        else $error("axis b direction not inverted");
    limit_uart_a: assert property (alt[0] && i_interface_select |=> o_left_limit[0] == $past(i_general_pin[0])) // RQ7
        else $error("axis a limit not from pin zero");
    limit_uart_b: assert property (alt[1] && i_interface_select |=> o_left_limit[1] == $past(i_general_pin[1])) // RQ8
        else $error("axis b limit not from pin one");
    poscmp_map_a: assert property (cfg.conf.poscmp_map |-> o_enc_a_pins_oe == 2'h3 ##1 o_enc_a_in == 2'h0) // RQ6
        else $error("encoder pins not remapped");

endmodule : gcr_route

// ---- hdl/gcr_top.sv ----
// How it works
// [RQ1] Config clears to zero at reset, status resets with its reset flag set
// [RQ2] Address byte plus 0x80 means write
// [RQ3] Bit 0 set: one motor, parallel stages
// [RQ4] Axis a external pins or ramp one
// [RQ5] Axis b external pins or ramp two
// [RQ6] Compare pulse and interrupt on encoder pins
// [RQ7] Axis a left limit follows interface select
// [RQ8] Axis b left limit follows interface select
// [RQ9] Host keeps test mode bit zero
// [RQ10] Bit 8 inverts axis a direction
// [RQ11] Bit 9 inverts axis b direction
// [RQ12] Lock bit blocks writes until reset
// [RQ13] Clear-on-read flags clear after read
`timescale 1ns/1ps
`include "gcr_regs.svh"
module gcr_top (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_access_strobe,
    input wire gcr_pkg::gcr_access_t i_access_address,
    input wire gcr_pkg::gcr_word_t i_access_wdata,
    output gcr_pkg::gcr_word_t o_read_data,
    output logic o_read_valid,
    input wire logic i_driver_a_fault,
    input wire logic i_driver_b_fault,
    input wire logic [`GCR_TEST_SEL_WIDTH-1:0] i_node_address_field,
    input wire logic i_ramp_a_step,
    input wire logic i_ramp_a_dir,
    input wire logic i_ramp_b_step,
    input wire logic i_ramp_b_dir,
    input wire logic i_axis_a_pulse_input,
    input wire logic i_axis_a_direction_input,
    input wire logic i_axis_b_pulse_input,
    input wire logic i_axis_b_direction_input,
    input wire logic i_interface_select,
    input wire logic i_axis_a_left_limit_input,
    input wire logic i_axis_b_left_limit_input,
    input wire logic i_axis_a_spi_limit_pin,
    input wire logic i_axis_b_spi_limit_pin,
    input wire logic i_general_pin_zero,
    input wire logic i_general_pin_one,
    input wire logic i_position_compare_pulse,
    input wire logic i_position_irq,
    input wire logic [1:0] i_enc_a_pins,
    output logic o_drv_a_step,
    output logic o_drv_a_dir,
    output logic o_drv_b_step,
    output logic o_drv_b_dir,
    output logic o_single_motor,
    output logic o_ramp_a_unused,
    output logic o_ramp_b_unused,
    output logic o_axis_a_left_limit,
    output logic o_axis_b_left_limit,
    output logic [1:0] o_enc_a_pins_out,
    output logic [1:0] o_enc_a_pins_oe,
    output logic [1:0] o_enc_a_in,
    output logic o_enc_b_enable,
    output logic o_test_mode,
    output logic [`GCR_TEST_SEL_WIDTH-1:0] o_test_select
);
    import gcr_pkg::*;

    gcr_cfg_if cfg ();

    logic [`GCR_CONF_WIDTH-1:0] conf_q;
    logic [`GCR_STATUS_WIDTH-1:0] status_q;
    logic [`GCR_STATUS_WIDTH-1:0] status_set;
    logic [`GCR_TEST_SEL_WIDTH-1:0] test_select_q;
    gcr_word_t read_data_q;
    logic read_valid_q;
    gcr_index_t index;
    logic wr;
    logic rd;
    logic conf_wr;
    logic status_rd;
    logic [1:0] drv_step;
    logic [1:0] drv_dir;
    logic [1:0] ramp_unused;
    logic [1:0] left_limit;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    assign index = i_access_address[6:0];
    assign wr = i_access_strobe && i_access_address[`GCR_WRITE_BIT]; // RQ2
    assign rd = i_access_strobe && !i_access_address[`GCR_WRITE_BIT]; // RQ2
    assign conf_wr = wr && index == `GCR_ADDR_CONF;
    assign status_rd = rd && index == `GCR_ADDR_STATUS;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            conf_q <= `GCR_CONF_RESET; // RQ1
        end else if (conf_wr && !conf_q[`GCR_BIT_LOCK]) begin // RQ12
            conf_q <= i_access_wdata[`GCR_CONF_WIDTH-1:0];
        end
    end

    assign cfg.conf = gcr_conf_s'(conf_q);

    ////////////////////////////////////////////////////////////////////////////
    // Clear-on-read status; a new event wins over the clear
    assign status_set = {i_driver_b_fault, i_driver_a_fault, 1'b0};

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            status_q <= `GCR_STATUS_RESET;
        end else begin
            status_q <= (status_rd ? '0 : status_q) | status_set; // RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path, one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            read_data_q <= '0;
            read_valid_q <= 1'b0;
        end else begin
            read_valid_q <= rd;
            if (rd) begin
                case (index)
                    `GCR_ADDR_CONF: read_data_q <= {21'h0, conf_q};
                    `GCR_ADDR_STATUS: read_data_q <= {29'h0, status_q}; // RQ13
                    default: read_data_q <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test output select, only meaningful with test mode set
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            test_select_q <= '0;
        end else begin
            test_select_q <= conf_q[`GCR_BIT_TEST_MODE] ? i_node_address_field : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing
    gcr_route u_route (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .cfg(cfg.route),
        .i_ramp_step({i_ramp_b_step, i_ramp_a_step}),
        .i_ramp_dir({i_ramp_b_dir, i_ramp_a_dir}),
        .i_pin_step({i_axis_b_pulse_input, i_axis_a_pulse_input}),
        .i_pin_dir({i_axis_b_direction_input, i_axis_a_direction_input}),
        .i_interface_select(i_interface_select),
        .i_left_limit_pin({i_axis_b_left_limit_input, i_axis_a_left_limit_input}),
        .i_spi_limit_pin({i_axis_b_spi_limit_pin, i_axis_a_spi_limit_pin}),
        .i_general_pin({i_general_pin_one, i_general_pin_zero}),
        .i_position_compare_pulse(i_position_compare_pulse),
        .i_position_irq(i_position_irq),
        .i_enc_a_pins(i_enc_a_pins),
        .o_drv_step(drv_step),
        .o_drv_dir(drv_dir),
        .o_ramp_unused(ramp_unused),
        .o_left_limit(left_limit),
        .o_enc_a_pins_out(o_enc_a_pins_out),
        .o_enc_a_pins_oe(o_enc_a_pins_oe),
        .o_enc_a_in(o_enc_a_in)
    );

    assign o_drv_a_step = drv_step[0];
    assign o_drv_b_step = drv_step[1];
    assign o_drv_a_dir = drv_dir[0];
    assign o_drv_b_dir = drv_dir[1];
    assign o_ramp_a_unused = ramp_unused[0];
    assign o_ramp_b_unused = ramp_unused[1];
    assign o_axis_a_left_limit = left_limit[0];
    assign o_axis_b_left_limit = left_limit[1];
    assign o_single_motor = conf_q[`GCR_BIT_SINGLE]; // RQ3
    assign o_enc_b_enable = conf_q[`GCR_BIT_B_ENC_ENABLE];
    assign o_test_mode = conf_q[`GCR_BIT_TEST_MODE];
    assign o_test_select = test_select_q;
    assign o_read_data = read_data_q;
    assign o_read_valid = read_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence lock_set_s;
        conf_wr && !conf_q[`GCR_BIT_LOCK] && i_access_wdata[`GCR_BIT_LOCK];
    endsequence

    sequence later_write_s;
        ##[1:8] conf_wr;
    endsequence

    reset_clear_a: assert property ($past(i_reset) |-> conf_q == `GCR_CONF_RESET
        && status_q[`GCR_ST_RESET]) // RQ1
        else $error("registers not at reset value");
    conf_write_a: assert property (conf_wr && !conf_q[`GCR_BIT_LOCK] |=>
        conf_q == $past(i_access_wdata[`GCR_CONF_WIDTH-1:0])) // RQ2
        else $error("write not stored");
    read_only_a: assert property (rd |=> $stable(conf_q) ##0 o_read_valid) // RQ2
        else $error("read changed config or gave no answer");
    lock_hold_a: assert property (lock_set_s ##0 later_write_s |=> conf_q[`GCR_BIT_LOCK]
        && $stable(conf_q)) // RQ12
        else $error("locked config changed");
    status_read_a: assert property (status_rd |=> o_read_data == {29'h0, $past(status_q)}) // RQ13
        else $error("status read wrong");
    status_clear_a: assert property (status_rd && status_set == '0 |=> status_q == '0) // RQ13
        else $error("status not cleared by read");
    fault_wins_a: assert property (i_driver_a_fault |=> status_q[`GCR_ST_DRV_A]) // RQ13
        else $error("fault flag lost");
    test_select_a: assert property (!o_test_mode |=> o_test_select == '0) // RQ9
        else $error("test select active outside test mode");

endmodule : gcr_top

// ---- sim/gcr_host_model.sv ----
`timescale 1ns/1ps
module gcr_host_model (
    input wire logic i_clk,
    output logic o_access_strobe,
    output gcr_pkg::gcr_access_t o_access_address,
    output gcr_pkg::gcr_word_t o_access_wdata,
    input wire gcr_pkg::gcr_word_t i_read_data,
    input wire logic i_read_valid
);
    import gcr_pkg::*;
    initial begin
        o_access_strobe = 1'b0;
        o_access_address = 8'h00;
        o_access_wdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////////
    // Released lines show the inverse so stale values never match
    task automatic access(input gcr_access_t addr, input gcr_word_t data);
        @(posedge i_clk);
        o_access_strobe <= 1'b1;
        o_access_address <= addr;
        o_access_wdata <= data;
        @(posedge i_clk);
        o_access_strobe <= 1'b0;
        o_access_address <= ~addr;
        o_access_wdata <= ~data;
    endtask : access
    task automatic write_reg(input gcr_index_t idx, input gcr_word_t data, input logic allow_test);
        gcr_word_t d;
        d = data;
        if (!allow_test) begin
            d[7] = 1'b0;
        end
        access(8'h80 | {1'b0, idx}, d);
    endtask : write_reg
    task automatic read_reg(input gcr_index_t idx, output gcr_word_t data, output logic valid);
        access({1'b0, idx}, 32'hffffffff);
        #1;
        valid = i_read_valid;
        data = i_read_data;
    endtask : read_reg
endmodule : gcr_host_model

// ---- sim/test_global_config_register.sv ----
`timescale 1ns/1ps
module test_global_config_register;
    import gcr_pkg::*;
    logic clk, rst, stb, sel, pulse, irq, fa, fb, rvalid, single, encb, tmode;
    logic [3:0] ramp, pins, drv, node, tsel;
    logic [1:0] lim, sp, gp, enc, unused, olim, pout, poe, ein;
    gcr_access_t addr;
    gcr_word_t wdata, rdata;
    int fail_count, tests_run;
    gcr_host_model host (.i_clk(clk), .o_access_strobe(stb), .o_access_address(addr),
        .o_access_wdata(wdata), .i_read_data(rdata), .i_read_valid(rvalid));
    gcr_top dut (.i_clk(clk), .i_reset(rst), .i_access_strobe(stb), .i_access_address(addr),
        .i_access_wdata(wdata), .o_read_data(rdata), .o_read_valid(rvalid), .i_driver_a_fault(fa),
        .i_driver_b_fault(fb), .i_node_address_field(node), .i_ramp_a_step(ramp[0]),
        .i_ramp_a_dir(ramp[1]), .i_ramp_b_step(ramp[2]), .i_ramp_b_dir(ramp[3]),
        .i_axis_a_pulse_input(pins[0]), .i_axis_a_direction_input(pins[1]),
        .i_axis_b_pulse_input(pins[2]), .i_axis_b_direction_input(pins[3]),
        .i_interface_select(sel), .i_axis_a_left_limit_input(lim[0]), .i_axis_b_left_limit_input(lim[1]),
        .i_axis_a_spi_limit_pin(sp[0]), .i_axis_b_spi_limit_pin(sp[1]), .i_general_pin_zero(gp[0]),
        .i_general_pin_one(gp[1]), .i_position_compare_pulse(pulse), .i_position_irq(irq),
        .i_enc_a_pins(enc), .o_drv_a_step(drv[0]), .o_drv_a_dir(drv[1]), .o_drv_b_step(drv[2]),
        .o_drv_b_dir(drv[3]), .o_single_motor(single), .o_ramp_a_unused(unused[0]),
        .o_ramp_b_unused(unused[1]), .o_axis_a_left_limit(olim[0]), .o_axis_b_left_limit(olim[1]),
        .o_enc_a_pins_out(pout), .o_enc_a_pins_oe(poe), .o_enc_a_in(ein), .o_enc_b_enable(encb),
        .o_test_mode(tmode), .o_test_select(tsel));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic rd(input gcr_index_t idx, input gcr_word_t exp, input string name);
        gcr_word_t v;
        logic ok;
        host.read_reg(idx, v, ok);
        check("read valid", {31'h0, ok}, 32'h1);
        check(name, v, exp);
    endtask : rd
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        rd(7'h00, 32'h0, "conf");
        rd(7'h01, 32'h1, "status");
        rd(7'h01, 32'h0, "status cleared");
        check("idle outs", {21'h0, single, unused, poe, encb, tmode, tsel}, 32'h0);
    endtask : test_reset_values
    task automatic test_drive;
        logic [10:0] cfgs [8] = '{11'h000, 11'h002, 11'h004, 11'h306, 11'h100, 11'h200, 11'h301, 11'h003};
        logic [10:0] c;
        logic [1:0] a, b;
        foreach (cfgs[i]) begin
            c = cfgs[i];
            host.write_reg(7'h00, {21'h0, c}, 1'b1);
            rd(7'h00, {21'h0, c}, "conf readback");
            for (int p = 0; p < 2; p++) begin
                @(posedge clk);
                ramp <= p ? 4'b1010 : 4'b0101;
                pins <= p ? 4'b0101 : 4'b1010;
                tick(2);
                a = c[1] ? pins[1:0] : ramp[1:0];
                b = c[2] ? pins[3:2] : ramp[3:2];
                a[1] = a[1] ^ c[8];
                b[1] = b[1] ^ c[9];
                if (c[0]) b = a;
                check("drive", {28'h0, drv}, {28'h0, b, a});
            end
            check("mode", {29'h0, single, unused}, {29'h0, c[0], c[2:1]});
        end
    endtask : test_drive
    task automatic test_limits;
        logic ea, eb;
        for (int c = 0; c < 4; c++) begin
            host.write_reg(7'h00, {25'h0, c[1], 1'b0, c[0], 4'h0}, 1'b1);
            for (int s = 0; s < 2; s++) begin
                for (int p = 0; p < 64; p++) begin
                    @(posedge clk);
                    sel <= s[0];
                    {lim, sp, gp} <= p[5:0];
                    tick(2);
                    ea = c[0] ? (sel ? gp[0] : sp[0]) : lim[0];
                    eb = c[1] ? (sel ? gp[1] : sp[1]) : lim[1];
                    check("limit", {30'h0, olim}, {30'h0, eb, ea});
                end
            end
        end
    endtask : test_limits
    task automatic test_map;
        for (int m = 0; m < 2; m++) begin
            host.write_reg(7'h00, m ? 32'h8 : 32'h0, 1'b1);
            for (int p = 0; p < 4; p++) begin
                @(posedge clk);
                {irq, pulse} <= p[1:0];
                enc <= ~p[1:0];
                tick(2);
                check("map oe", {30'h0, poe}, m ? 32'h3 : 32'h0);
                if (m) check("map out", {30'h0, pout}, {30'h0, irq, pulse});
                check("enc in", {30'h0, ein}, m ? 32'h0 : {30'h0, enc});
            end
        end
    endtask : test_map
    task automatic test_test_mode;
        @(posedge clk);
        node <= 4'h5;
        host.write_reg(7'h00, 32'ha0, 1'b1);
        tick(2);
        check("test on", {26'h0, tmode, encb, tsel}, 32'h35);
        host.write_reg(7'h00, 32'ha0, 1'b0);
        rd(7'h00, 32'h20, "test off");
        check("test outs", {26'h0, tmode, encb, tsel}, 32'h10);
    endtask : test_test_mode
    task automatic test_status;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {fb, fa} <= 2'b01 << k;
            @(posedge clk);
            {fb, fa} <= 2'b00;
            rd(7'h01, 32'h2 << k, "fault");
            rd(7'h01, 32'h0, "fault cleared");
        end
        host.write_reg(7'h01, 32'h7, 1'b1);
        rd(7'h01, 32'h0, "status write");
        rd(7'h05, 32'h0, "unmapped");
    endtask : test_status
    task automatic test_lock;
        host.write_reg(7'h00, 32'h401, 1'b1);
        rd(7'h00, 32'h401, "locked");
        host.write_reg(7'h00, 32'h002, 1'b1);
        rd(7'h00, 32'h401, "lock holds");
        check("lock single", {31'h0, single}, 32'h1);
        do_reset();
        rd(7'h00, 32'h0, "conf after reset");
        host.write_reg(7'h00, 32'h002, 1'b1);
        rd(7'h00, 32'h002, "unlocked");
    endtask : test_lock
    ////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        fail_count++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        {sel, pulse, irq, fa, fb} = 5'h00;
        {ramp, pins, node} = 12'h000;
        {lim, sp, gp, enc} = 8'h00;
        fail_count = 0;
        tests_run = 0;
        do_reset();
        test_reset_values();
        test_drive();
        test_limits();
        test_map();
        test_test_mode();
        test_status();
        test_lock();
        close_out();
    end
endmodule : test_global_config_register
